// >>> bmx_map.svh
// Purpose: Named encodings, field positions and reset values of the byte move/inc/or executor
// Assumes: 14-bit instruction words, 7-bit file addresses, 8-bit data
// Notes: Definitions only
`ifndef BMX_MAP_SVH
`define BMX_MAP_SVH

// Instruction field positions
`define BMX_INSTR_W 14
`define BMX_OPC6_HI 13
`define BMX_OPC6_LO 8
`define BMX_OPC4_HI 13
`define BMX_OPC4_LO 10
`define BMX_DEST_BIT 7
`define BMX_FADDR_HI 6
`define BMX_FADDR_LO 0
`define BMX_LIT_HI 7
`define BMX_LIT_LO 0

// Six-bit opcodes of byte-oriented instructions
`define BMX_OPC_INC 6'h0a
`define BMX_OPC_OR 6'h04
`define BMX_OPC_MOVE 6'h08
`define BMX_OPC_STORE 6'h00
// Four-bit opcode of the literal load, two don't-care bits follow
`define BMX_OPC_LIT 4'hc

// Destination bit values
`define BMX_DEST_WORK 1'h0
`define BMX_DEST_FILE 1'h1

// Arithmetic and reset constants
`define BMX_ONE 8'h01
`define BMX_ZERO 8'h00
`define BMX_W_RST 8'h00
`define BMX_Z_RST 1'h0
`define BMX_ADDR_RST 7'h00

`endif

// >>> bmx_pkg.sv
// Purpose: Types shared by the byte move/inc/or executor
// Assumes: Nothing beyond the map header
// Notes: Types only
`default_nettype none
package bmx_pkg;

  typedef enum logic [2:0] {
    BMX_OP_NONE = 3'h0,
    BMX_OP_INC = 3'h1,
    BMX_OP_OR = 3'h2,
    BMX_OP_MOVE = 3'h3,
    BMX_OP_STORE = 3'h4,
    BMX_OP_LIT = 3'h5
  } bmx_op_t;

  // Gray codes along idle -> exec -> idle
  typedef enum logic [1:0] {
    BMX_ST_IDLE = 2'h0,
    BMX_ST_EXEC = 2'h1
  } bmx_state_t;

  typedef struct packed {
    bmx_state_t state;
    logic [7:0] w;
    logic z;
    logic z_upd;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic done;
    logic illegal;
    bmx_op_t last_op;
  } bmx_regs_t;

endpackage
`default_nettype wire

// >>> bmx_decode.sv
// Purpose: Opcode decode for the byte move/inc/or executor
// Assumes: Instruction word is stable while valid
// Notes: Purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "bmx_map.svh"

module bmx_decode
(
  // Instruction
  input wire logic [13:0] instr,
  // Decoded fields
  output bmx_pkg::bmx_op_t op,
  output logic dest_file,
  output logic [6:0] faddr,
  output logic [7:0] literal
);
  import bmx_pkg::*;

  logic [5:0] opc6;
  logic [3:0] opc4;

  assign opc6 = instr[`BMX_OPC6_HI:`BMX_OPC6_LO];
  assign opc4 = instr[`BMX_OPC4_HI:`BMX_OPC4_LO];
  assign faddr = instr[`BMX_FADDR_HI:`BMX_FADDR_LO];
  assign literal = instr[`BMX_LIT_HI:`BMX_LIT_LO];
  assign dest_file = instr[`BMX_DEST_BIT];

  always_comb
  begin
    op = BMX_OP_NONE;
    if (opc4 == `BMX_OPC_LIT)
    begin
      op = BMX_OP_LIT;
    end
    else
    begin
      case (opc6)
        `BMX_OPC_INC: op = BMX_OP_INC;
        `BMX_OPC_OR: op = BMX_OP_OR;
        `BMX_OPC_MOVE: op = BMX_OP_MOVE;
        `BMX_OPC_STORE: op = instr[`BMX_DEST_BIT] ? BMX_OP_STORE : BMX_OP_NONE;
        default: op = BMX_OP_NONE;
      endcase
    end
  end

endmodule // bmx_decode
`default_nettype wire

// >>> bmx_exec.sv
// Purpose: Executes increment, OR with file, move from file, move to file and literal load
// Assumes: File register read data is valid combinationally for file_rd_addr
// Notes: One instruction per cycle; results appear at the edge after the request
//
// What this block does
// - Increment addressed file value, send sum to destination, update zero flag.
// - OR working register with addressed file value, result to destination, update zero.
// - Destination bit 0 writes working register; 1 writes the addressed file register.
// - Move file value to destination, zero flag from value; one word, one cycle.
// - Store working register to addressed file register; flags untouched; one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "bmx_map.svh"

module bmx_exec
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Instruction request
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  // File register read port
  output logic [6:0] file_rd_addr,
  input wire logic [7:0] file_rd_data,
  // File register write port
  output logic file_wr_en,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  // Status
  output logic [7:0] work_reg,
  output logic zero_flag,
  output logic zero_upd,
  output logic done,
  output logic illegal_op,
  output bmx_pkg::bmx_op_t last_op
);
  import bmx_pkg::*;

  bmx_regs_t cur_r;
  bmx_regs_t cur_nxt;

  bmx_op_t op;
  logic dest_file;
  logic [6:0] faddr;
  logic [7:0] literal;

  logic [7:0] result;
  logic result_valid;
  logic result_sets_z;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `BMX_ZERO);
  endfunction

  bmx_decode u_decode
  (
    .instr(instr),
    .op(op),
    .dest_file(dest_file),
    .faddr(faddr),
    .literal(literal)
  );

  // Read address follows the instruction
  assign file_rd_addr = faddr;

  // Result computation
  always_comb
  begin
    result = `BMX_ZERO;
    result_valid = 1'b0;
    result_sets_z = 1'b0;
    case (op)
      BMX_OP_INC:
      begin
        result = file_rd_data + `BMX_ONE;
        result_valid = 1'b1;
        result_sets_z = 1'b1;
      end
      BMX_OP_OR:
      begin
        result = cur_r.w | file_rd_data;
        result_valid = 1'b1;
        result_sets_z = 1'b1;
      end
      BMX_OP_MOVE:
      begin
        result = file_rd_data;
        result_valid = 1'b1;
        result_sets_z = 1'b1;
      end
      BMX_OP_STORE:
      begin
        result = cur_r.w;
        result_valid = 1'b1;
        result_sets_z = 1'b0;
      end
      BMX_OP_LIT:
      begin
        result = literal;
        result_valid = 1'b1;
        result_sets_z = 1'b0;
      end
      default:
      begin
        result = `BMX_ZERO;
        result_valid = 1'b0;
        result_sets_z = 1'b0;
      end
    endcase
  end

  // Next state
  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.wr_en = 1'b0;
    cur_nxt.z_upd = 1'b0;
    cur_nxt.done = 1'b0;
    cur_nxt.illegal = 1'b0;
    case (cur_r.state)
      BMX_ST_IDLE, BMX_ST_EXEC:
      begin
        if (instr_valid)
        begin
          cur_nxt.state = BMX_ST_EXEC;
          cur_nxt.last_op = op;
          if (result_valid)
          begin
            cur_nxt.done = 1'b1;
            if (op == BMX_OP_STORE)
            begin
              cur_nxt.wr_en = 1'b1;
              cur_nxt.wr_addr = faddr;
              cur_nxt.wr_data = result;
            end
            else if (op == BMX_OP_LIT)
            begin
              cur_nxt.w = result;
            end
            else if (dest_file == `BMX_DEST_FILE)
            begin
              cur_nxt.wr_en = 1'b1;
              cur_nxt.wr_addr = faddr;
              cur_nxt.wr_data = result;
            end
            else
            begin
              cur_nxt.w = result;
            end
            if (result_sets_z)
            begin
              cur_nxt.z = is_zero(result);
              cur_nxt.z_upd = 1'b1;
            end
          end
          else
          begin
            cur_nxt.illegal = 1'b1;
          end
        end
        else
        begin
          cur_nxt.state = BMX_ST_IDLE;
        end
      end
      default:
      begin
        cur_nxt.state = BMX_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cur_r.state <= BMX_ST_IDLE;
      cur_r.w <= `BMX_W_RST;
      cur_r.z <= `BMX_Z_RST;
      cur_r.z_upd <= 1'b0;
      cur_r.wr_en <= 1'b0;
      cur_r.wr_addr <= `BMX_ADDR_RST;
      cur_r.wr_data <= `BMX_ZERO;
      cur_r.done <= 1'b0;
      cur_r.illegal <= 1'b0;
      cur_r.last_op <= BMX_OP_NONE;
    end
    else
    begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs
  assign file_wr_en = cur_r.wr_en;
  assign file_wr_addr = cur_r.wr_addr;
  assign file_wr_data = cur_r.wr_data;
  assign work_reg = cur_r.w;
  assign zero_flag = cur_r.z;
  assign zero_upd = cur_r.z_upd;
  assign done = cur_r.done;
  assign illegal_op = cur_r.illegal;
  assign last_op = cur_r.last_op;

endmodule // bmx_exec
`default_nettype wire

// >>> bmx_checker.sv
// Purpose: Port assertions for the byte move/inc/or executor
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to bmx_exec below
`timescale 1ns/10ps
`default_nettype none
module bmx_checker
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Request
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  // File ports
  input wire logic [6:0] file_rd_addr,
  input wire logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [6:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  // Status
  input wire logic [7:0] work_reg,
  input wire logic zero_flag,
  input wire logic zero_upd,
  input wire logic done,
  input wire logic illegal_op,
  input wire bmx_pkg::bmx_op_t last_op
);
  import bmx_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  inc_to_file_a: assert property (instr_valid && instr[13:7] == 7'h15
    |=> file_wr_en && file_wr_data == $past(file_rd_data) + 8'h01 && zero_upd
    && zero_flag == (file_wr_data == 8'h00)) else $error("increment result wrong");
  or_to_work_a: assert property (instr_valid && instr[13:7] == 7'h08
    |=> work_reg == ($past(work_reg) | $past(file_rd_data)) && zero_upd
    && zero_flag == (work_reg == 8'h00)) else $error("or result wrong");
  dest_work_a: assert property (instr_valid && instr[13:7] inside {7'h14, 7'h08, 7'h10}
    |=> !file_wr_en && done) else $error("work destination wrote the file");
  move_zero_a: assert property (instr_valid && instr[13:8] == 6'h08
    |=> done && zero_upd && zero_flag == ($past(file_rd_data) == 8'h00))
    else $error("move zero flag wrong");
  store_work_a: assert property (instr_valid && instr[13:7] == 7'h01
    |=> file_wr_en && file_wr_data == $past(work_reg) && file_wr_addr == $past(file_rd_addr)
    && !zero_upd && $stable(zero_flag)) else $error("store of work register wrong");
  load_lit_a: assert property (instr_valid && instr[13:10] == 4'hc
    |=> work_reg == $past(instr[7:0]) && !zero_upd
    && $stable(zero_flag) && done) else $error("literal load wrong");
  illegal_store_a: assert property (instr_valid && instr[13:7] == 7'h00
    |=> illegal_op && !done && !file_wr_en && !zero_upd
    && $stable(work_reg) && $stable(zero_flag)) else $error("refused store changed state");
endmodule // bmx_checker
bind bmx_exec bmx_checker i_bmx_checker (.ref_clk(ref_clk), .rst_b(rst_b),
  .instr_valid(instr_valid), .instr(instr), .file_rd_addr(file_rd_addr),
  .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
  .file_wr_data(file_wr_data), .work_reg(work_reg), .zero_flag(zero_flag),
  .zero_upd(zero_upd), .done(done), .illegal_op(illegal_op), .last_op(last_op));
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the byte move/inc/or executor
// Assumes: One-cycle answer, combinational file read
// Notes: Each instruction is followed by one idle cycle except the back-to-back pair
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rd_data = 8'h00;
  logic [6:0] file_rd_addr;
  logic file_wr_en;
  logic [6:0] file_wr_addr;
  logic [7:0] file_wr_data;
  logic [7:0] work_reg;
  logic zero_flag;
  logic zero_upd;
  logic done;
  logic illegal_op;
  bmx_pkg::bmx_op_t last_op;
  int bad_count = 0;
  int total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  bmx_exec i_bmx_exec (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .work_reg(work_reg), .zero_flag(zero_flag), .zero_upd(zero_upd), .done(done),
    .illegal_op(illegal_op), .last_op(last_op));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ex(input logic [13:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= i;
    file_rd_data <= d;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    file_rd_data <= ~d;
    #1;
  endtask
  task automatic t_inc();
    ex(14'h0a90, 8'hff);
    chk("wr_en", file_wr_en, 8'h01);
    chk("wr_addr", file_wr_addr, 8'h10);
    chk("wr_data", file_wr_data, 8'h00);
    chk("zero", zero_flag, 8'h01);
    ex(14'h0a7f, 8'h7f);
    chk("work", work_reg, 8'h80);
    chk("wr_en", file_wr_en, 8'h00);
    chk("zero", zero_flag, 8'h00);
    $display("test increment done");
  endtask
  task automatic t_lit();
    ex(14'h33a5, 8'h00);
    chk("work", work_reg, 8'ha5);
    chk("zero_upd", zero_upd, 8'h00);
    chk("done", done, 8'h01);
    $display("test literal done");
  endtask
  task automatic t_or();
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= 14'h300f;
    @(posedge ref_clk);
    instr <= 14'h0422;
    file_rd_data <= 8'hf0;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    chk("work", work_reg, 8'hff);
    chk("wr_en", file_wr_en, 8'h00);
    chk("zero", zero_flag, 8'h00);
    chk("last_op", last_op, 8'h02);
    ex(14'h04a2, 8'h00);
    chk("wr_en", file_wr_en, 8'h01);
    chk("wr_addr", file_wr_addr, 8'h22);
    chk("wr_data", file_wr_data, 8'hff);
    chk("work", work_reg, 8'hff);
    chk("zero_upd", zero_upd, 8'h01);
    $display("test or done");
  endtask
  task automatic t_move();
    ex(14'h0801, 8'h3c);
    chk("work", work_reg, 8'h3c);
    chk("zero", zero_flag, 8'h00);
    ex(14'h08ff, 8'h00);
    chk("wr_data", file_wr_data, 8'h00);
    chk("zero", zero_flag, 8'h01);
    ex(14'h0085, 8'h99);
    chk("wr_en", file_wr_en, 8'h01);
    chk("wr_addr", file_wr_addr, 8'h05);
    chk("wr_data", file_wr_data, 8'h3c);
    chk("zero", zero_flag, 8'h01);
    chk("last_op", last_op, 8'h04);
    $display("test move done");
  endtask
  task automatic t_illegal();
    ex(14'h0005, 8'h00);
    chk("illegal", illegal_op, 8'h01);
    chk("done", done, 8'h00);
    chk("wr_en", file_wr_en, 8'h00);
    chk("work", work_reg, 8'h3c);
    chk("last_op", last_op, 8'h00);
    $display("test illegal done");
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("work", work_reg, 8'h00);
    chk("zero", zero_flag, 8'h00);
    chk("wr_addr", file_wr_addr, 8'h00);
    chk("wr_data", file_wr_data, 8'h00);
    chk("done", done, 8'h00);
    ex(14'h305a, 8'h00);
    chk("work", work_reg, 8'h5a);
    chk("last_op", last_op, 8'h05);
    $display("test reset done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("work", work_reg, 8'h00);
    chk("zero", zero_flag, 8'h00);
    t_inc();
    t_lit();
    t_or();
    t_move();
    t_illegal();
    t_reset();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
